// ### kbg_pkg.sv
package kbg_pkg;
	localparam int ADDR_W = 12;
	// Register indices; each byte address is four times its index.
	localparam logic [ADDR_W-1:0] IDX_CTRL_RESET = 12'h02C;
	localparam logic [ADDR_W-1:0] IDX_GLUE = 12'h0F0;
	localparam logic [ADDR_W-1:0] IDX_FAST_PORT = 12'h092;
	localparam logic [ADDR_W-1:0] IDX_WAKE_STAT = 12'h0F8;
	localparam logic [ADDR_W-1:0] IDX_WAKE_EN = 12'h0F9;
	localparam logic [ADDR_W-1:0] IDX_IRQ_STAT = 12'h0FA;
	localparam logic [ADDR_W-1:0] IDX_IRQ_MASK = 12'h0FB;
	localparam logic [ADDR_W-1:0] A_CTRL_RESET = IDX_CTRL_RESET << 2;
	localparam logic [ADDR_W-1:0] A_GLUE = IDX_GLUE << 2;
	localparam logic [ADDR_W-1:0] A_FAST_PORT = IDX_FAST_PORT << 2;
	localparam logic [ADDR_W-1:0] A_WAKE_STAT = IDX_WAKE_STAT << 2;
	localparam logic [ADDR_W-1:0] A_WAKE_EN = IDX_WAKE_EN << 2;
	localparam logic [ADDR_W-1:0] A_IRQ_STAT = IDX_IRQ_STAT << 2;
	localparam logic [ADDR_W-1:0] A_IRQ_MASK = IDX_IRQ_MASK << 2;
	// Field positions.
	localparam int CTRL_KBC_RESET_BIT = 6;
	localparam int GLUE_FAST_EN_BIT = 2;
	localparam int GLUE_KEY_LATCH_BIT = 3;
	localparam int GLUE_MOUSE_LATCH_BIT = 4;
	localparam int GLUE_KEY_ISO_BIT = 5;
	localparam int GLUE_MOUSE_ISO_BIT = 6;
	localparam int FAST_RESET_BIT = 0;
	localparam int FAST_GATE_BIT = 1;
	localparam int WAKE_KEY_IRQ = 0;
	localparam int WAKE_MOUSE_IRQ = 1;
	localparam int WAKE_KEY_DATA = 2;
	localparam int WAKE_MOUSE_DATA = 3;
	localparam int WAKE_GLOBAL_BIT = 4;
	localparam int IRQ_RESET_PULSE = 0;
	localparam int IRQ_WAKE_RISE = 1;
	// Reset values, fixed fast port bits and response codes.
	localparam logic [7:0] CTRL_RESET_RST = 8'h00;
	localparam logic [7:0] GLUE_RST = 8'h00;
	localparam logic [7:0] FAST_PORT_RST = 8'h24;
	localparam logic [7:0] FAST_PORT_FIXED = 8'h24;
	localparam logic [4:0] WAKE_EN_RST = 5'h00;
	localparam logic [1:0] IRQ_MASK_RST = 2'h0;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// Timing of the fast reset pulse.
	localparam int CLK_PERIOD_NS = 8;
	localparam int RESET_DELAY_US = 14;
	localparam int RESET_PULSE_US = 6;
	localparam int RESET_DELAY_CYC = (RESET_DELAY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RESET_PULSE_CYC = (RESET_PULSE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	typedef enum logic [1:0] {
		KBG_FR_IDLE = 2'h0,
		KBG_FR_DELAY = 2'h1,
		KBG_FR_PULSE = 2'h3,
		KBG_FR_DONE = 2'h2
	} kbg_fr_state_t;
endpackage

// ### kbg_glue.sv
`timescale 1ns/1ps
// Notes on behaviour
// R1 - Mask high if controller bit or fast gate high
// R2 - Bit 0 write: 14us delay, 6us low pulse
// R3 - Next pulse only after bit 0 cleared
// R4 - Reset clears bit 0, reset output high
// R5 - Enabled fast pulse ANDed with controller reset
// R6 - Keyboard reset pin polarity follows pin config
// R7 - Bit 1 drives fast gate level
// R8 - Reset drives fast gate low
// R9 - Bit 4 picks mouse interrupt source
// R10 - Bit 3 picks keyboard interrupt source
// R11 - Interrupts and data edges set wake status
// R12 - Wake needs own and global enable
// R13 - Interrupt wakes need main power; edges not
// R14 - Bit 6 isolates mouse lines from controller
// R15 - Bit 5 isolates keyboard lines from controller
// R16 - Software pulses controller reset via 0x40/0x00
// R17 - Software resets controller after power loss
// R18 - Fast port reads fixed bits, default 24h
// R19 - Counter on device clock times the pulse
module kbg_glue #(
	parameter int CNT_W = 12
) (
	input wire logic clk, // Device clock.
	input wire logic rst_n, // Asynchronous system reset.
	input wire logic ce, // Clock enable; state frozen while low.
	input wire logic [kbg_pkg::ADDR_W-1:0] s_axi_awaddr, // Write address.
	input wire logic s_axi_awvalid, // Write address valid.
	output logic s_axi_awready, // Write address ready.
	input wire logic [31:0] s_axi_wdata, // Write data.
	input wire logic [3:0] s_axi_wstrb, // Write byte strobes.
	input wire logic s_axi_wvalid, // Write data valid.
	output logic s_axi_wready, // Write data ready.
	output logic [1:0] s_axi_bresp, // Write response.
	output logic s_axi_bvalid, // Write response valid.
	input wire logic s_axi_bready, // Write response ready.
	input wire logic [kbg_pkg::ADDR_W-1:0] s_axi_araddr, // Read address.
	input wire logic s_axi_arvalid, // Read address valid.
	output logic s_axi_arready, // Read address ready.
	output logic [31:0] s_axi_rdata, // Read data.
	output logic [1:0] s_axi_rresp, // Read response.
	output logic s_axi_rvalid, // Read data valid.
	input wire logic s_axi_rready, // Read data ready.
	input wire logic kbc_gate_port_bit, // Controller A20 port bit.
	input wire logic kbc_reset_out_n, // Controller reset, active low.
	input wire logic kbc_key_irq, // Raw controller keyboard interrupt.
	input wire logic kbc_mouse_irq, // Raw controller mouse interrupt.
	input wire logic kbc_data_read, // Host read of controller data, pulse.
	input wire logic main_power_on, // High while main power is present.
	input wire logic reset_pin_invert, // Keyboard reset pin polarity config.
	input wire logic key_clock_line, // Keyboard clock pin.
	input wire logic key_data_line, // Keyboard data pin.
	input wire logic mouse_clock_line, // Mouse clock pin.
	input wire logic mouse_data_line, // Mouse data pin.
	output logic cpu_addr_mask_n, // CPU A20 mask.
	output logic fast_reset_out_n, // Fast reset pulse, active low.
	output logic fast_gate_out, // Fast A20 gate.
	output logic keyboard_reset_pin, // Combined keyboard reset pin.
	output logic kbc_key_clock, // Keyboard clock to controller.
	output logic kbc_key_data, // Keyboard data to controller.
	output logic kbc_mouse_clock, // Mouse clock to controller.
	output logic kbc_mouse_data, // Mouse data to controller.
	output logic key_irq, // Selected keyboard interrupt.
	output logic mouse_irq, // Selected mouse interrupt.
	output logic kbc_hold_reset, // Holds the controller in reset.
	output logic wake_event, // Wake event output.
	output logic irq // Interrupt, level.
);
	localparam logic [CNT_W-1:0] DELAY_LAST = CNT_W'(kbg_pkg::RESET_DELAY_CYC - 1);
	localparam logic [CNT_W-1:0] PULSE_LAST = CNT_W'(kbg_pkg::RESET_PULSE_CYC - 1);

	// Bus channel state.
	logic aw_ready_q;
	logic w_ready_q;
	logic aw_have_q;
	logic w_have_q;
	logic b_valid_q;
	logic [1:0] b_resp_q;
	logic [kbg_pkg::ADDR_W-1:0] wr_addr_q;
	logic [7:0] wr_data_q;
	logic wr_lane_q;
	logic ar_ready_q;
	logic r_valid_q;
	logic [31:0] r_data_q;
	logic [1:0] r_resp_q;

	// Registers.
	logic [7:0] ctrl_reset_q;
	logic [7:0] glue_q;
	logic fast_rst_bit_q;
	logic fast_gate_q;
	logic [3:0] wake_stat_q;
	logic [3:0] wake_stat_d;
	logic [4:0] wake_en_q;
	logic [1:0] irq_stat_q;
	logic [1:0] irq_stat_d;
	logic [1:0] irq_mask_q;

	// Pin synchronisers: clocks and data of keyboard then mouse.
	logic [3:0] pin_meta_q;
	logic [3:0] pin_sync_q;
	logic [1:0] data_prev_q;

	logic [1:0] irq_prev_q;
	logic [1:0] irq_latch_q;
	kbg_pkg::kbg_fr_state_t fr_state_q;
	kbg_pkg::kbg_fr_state_t fr_state_d;
	logic [CNT_W-1:0] cnt_q;
	logic [CNT_W-1:0] cnt_d;

	logic out_mask_n_q;
	logic out_fr_n_q;
	logic out_kbd_pin_q;
	logic [3:0] out_kbc_lines_q;
	logic [1:0] out_irq_sel_q;
	logic out_wake_q;
	logic out_irq_q;

	// Write side decode.
	wire wr_fire = ce & aw_have_q & w_have_q & ~b_valid_q;
	wire wr_en = wr_fire & wr_lane_q;
	wire fast_en = glue_q[kbg_pkg::GLUE_FAST_EN_BIT];
	wire wr_ctrl = wr_en & (wr_addr_q == kbg_pkg::A_CTRL_RESET);
	wire wr_glue = wr_en & (wr_addr_q == kbg_pkg::A_GLUE);
	wire wr_fast = wr_en & (wr_addr_q == kbg_pkg::A_FAST_PORT) & fast_en;
	wire wr_wstat = wr_en & (wr_addr_q == kbg_pkg::A_WAKE_STAT);
	wire wr_wen = wr_en & (wr_addr_q == kbg_pkg::A_WAKE_EN);
	wire wr_imask = wr_en & (wr_addr_q == kbg_pkg::A_IRQ_MASK);
	wire wr_hit = (wr_addr_q == kbg_pkg::A_CTRL_RESET) | (wr_addr_q == kbg_pkg::A_GLUE) |
		(wr_addr_q == kbg_pkg::A_FAST_PORT) | (wr_addr_q == kbg_pkg::A_WAKE_STAT) |
		(wr_addr_q == kbg_pkg::A_WAKE_EN) | (wr_addr_q == kbg_pkg::A_IRQ_STAT) |
		(wr_addr_q == kbg_pkg::A_IRQ_MASK);

	// Read side decode.
	wire rd_fire = ce & s_axi_arvalid & ar_ready_q;
	wire rd_ctrl = (s_axi_araddr == kbg_pkg::A_CTRL_RESET);
	wire rd_glue = (s_axi_araddr == kbg_pkg::A_GLUE);
	wire rd_fast = (s_axi_araddr == kbg_pkg::A_FAST_PORT);
	wire rd_wstat = (s_axi_araddr == kbg_pkg::A_WAKE_STAT);
	wire rd_wen = (s_axi_araddr == kbg_pkg::A_WAKE_EN);
	wire rd_istat = (s_axi_araddr == kbg_pkg::A_IRQ_STAT);
	wire rd_imask = (s_axi_araddr == kbg_pkg::A_IRQ_MASK);
	wire rd_hit = rd_ctrl | rd_glue | rd_fast | rd_wstat | rd_wen | rd_istat | rd_imask;
	// The fast port reads as zero while it is disabled.
	wire [7:0] fast_rd = fast_en ?
		(kbg_pkg::FAST_PORT_FIXED | {6'h00, fast_gate_q, fast_rst_bit_q}) : 8'h00; // R18
	wire [7:0] rd_byte = rd_ctrl ? ctrl_reset_q :
		rd_glue ? glue_q :
		rd_fast ? fast_rd :
		rd_wstat ? {4'h0, wake_stat_q} :
		rd_wen ? {3'h0, wake_en_q} :
		rd_istat ? {6'h00, irq_stat_q} :
		rd_imask ? {6'h00, irq_mask_q} : 8'h00;

	// Write address and data are taken in either order.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			aw_ready_q <= 1'b1;
			aw_have_q <= 1'b0;
			wr_addr_q <= '0;
		end else if (ce) begin
			if (s_axi_awvalid & aw_ready_q) begin
				aw_ready_q <= 1'b0;
				aw_have_q <= 1'b1;
				wr_addr_q <= s_axi_awaddr;
			end else if (wr_fire) begin
				aw_have_q <= 1'b0;
			end else if (b_valid_q & s_axi_bready) begin
				aw_ready_q <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			w_ready_q <= 1'b1;
			w_have_q <= 1'b0;
			wr_data_q <= 8'h00;
			wr_lane_q <= 1'b0;
		end else if (ce) begin
			if (s_axi_wvalid & w_ready_q) begin
				w_ready_q <= 1'b0;
				w_have_q <= 1'b1;
				wr_data_q <= s_axi_wdata[7:0];
				wr_lane_q <= s_axi_wstrb[0];
			end else if (wr_fire) begin
				w_have_q <= 1'b0;
			end else if (b_valid_q & s_axi_bready) begin
				w_ready_q <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			b_valid_q <= 1'b0;
			b_resp_q <= kbg_pkg::RESP_OKAY;
		end else if (ce) begin
			if (wr_fire) begin
				b_valid_q <= 1'b1;
				b_resp_q <= wr_hit ? kbg_pkg::RESP_OKAY : kbg_pkg::RESP_SLVERR;
			end else if (s_axi_bready) begin
				b_valid_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ar_ready_q <= 1'b1;
			r_valid_q <= 1'b0;
			r_data_q <= 32'h0000_0000;
			r_resp_q <= kbg_pkg::RESP_OKAY;
		end else if (ce) begin
			if (rd_fire) begin
				ar_ready_q <= 1'b0;
				r_valid_q <= 1'b1;
				r_data_q <= {24'h00_0000, rd_byte};
				r_resp_q <= rd_hit ? kbg_pkg::RESP_OKAY : kbg_pkg::RESP_SLVERR;
			end else if (r_valid_q & s_axi_rready) begin
				r_valid_q <= 1'b0;
				ar_ready_q <= 1'b1;
			end
		end
	end

	// Configuration registers; the controller reset bit is held by software.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_reset_q <= kbg_pkg::CTRL_RESET_RST;
			glue_q <= kbg_pkg::GLUE_RST;
			wake_en_q <= kbg_pkg::WAKE_EN_RST;
			irq_mask_q <= kbg_pkg::IRQ_MASK_RST;
		end else if (ce) begin
			if (wr_ctrl)
				ctrl_reset_q <= wr_data_q; // R16
			if (wr_glue)
				glue_q <= wr_data_q;
			if (wr_wen)
				wake_en_q <= wr_data_q[4:0];
			if (wr_imask)
				irq_mask_q <= wr_data_q[1:0];
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			fast_rst_bit_q <= kbg_pkg::FAST_PORT_RST[kbg_pkg::FAST_RESET_BIT]; // R4
			fast_gate_q <= kbg_pkg::FAST_PORT_RST[kbg_pkg::FAST_GATE_BIT]; // R8
		end else if (ce && wr_fast) begin
			fast_rst_bit_q <= wr_data_q[kbg_pkg::FAST_RESET_BIT];
			fast_gate_q <= wr_data_q[kbg_pkg::FAST_GATE_BIT]; // R7
		end
	end

	// Fast reset sequencer; the done state waits for bit 0 to clear.
	always_comb begin
		fr_state_d = fr_state_q;
		cnt_d = cnt_q + CNT_W'(1); // R19
		unique case (fr_state_q)
			kbg_pkg::KBG_FR_IDLE: begin
				cnt_d = '0;
				if (fast_rst_bit_q)
					fr_state_d = kbg_pkg::KBG_FR_DELAY; // R2
			end
			kbg_pkg::KBG_FR_DELAY: begin
				if (cnt_q == DELAY_LAST) begin
					fr_state_d = kbg_pkg::KBG_FR_PULSE; // R2
					cnt_d = '0;
				end
			end
			kbg_pkg::KBG_FR_PULSE: begin
				if (cnt_q == PULSE_LAST) begin
					fr_state_d = kbg_pkg::KBG_FR_DONE; // R2
					cnt_d = '0;
				end
			end
			kbg_pkg::KBG_FR_DONE: begin
				cnt_d = '0;
				if (!fast_rst_bit_q)
					fr_state_d = kbg_pkg::KBG_FR_IDLE; // R3
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			fr_state_q <= kbg_pkg::KBG_FR_IDLE;
			cnt_q <= '0;
		end else if (ce) begin
			fr_state_q <= fr_state_d;
			cnt_q <= cnt_d;
		end
	end

	// Pins are synchronised before any logic looks at them.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pin_meta_q <= 4'hF;
			pin_sync_q <= 4'hF;
			data_prev_q <= 2'h3;
		end else if (ce) begin
			pin_meta_q <= {mouse_data_line, mouse_clock_line, key_data_line, key_clock_line};
			pin_sync_q <= pin_meta_q;
			data_prev_q <= {pin_sync_q[3], pin_sync_q[1]};
		end
	end

	// Interrupt latches set on a rising request and clear on a data read.
	wire [1:0] irq_raw = {kbc_mouse_irq, kbc_key_irq};
	wire [1:0] irq_rise = irq_raw & ~irq_prev_q;
	wire [1:0] latch_sel = {glue_q[kbg_pkg::GLUE_MOUSE_LATCH_BIT],
		glue_q[kbg_pkg::GLUE_KEY_LATCH_BIT]};
	wire [1:0] irq_sel = (latch_sel & irq_latch_q) | (~latch_sel & irq_latch_q & irq_raw); // R9 R10

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_prev_q <= 2'h0;
			irq_latch_q <= 2'h0;
		end else if (ce) begin
			irq_prev_q <= irq_raw;
			irq_latch_q <= irq_rise | (irq_latch_q & ~{2{kbc_data_read}});
		end
	end

	// Data lines fall at the start of a frame; that edge is the wake cause.
	wire [1:0] data_fall = data_prev_q & ~{pin_sync_q[3], pin_sync_q[1]};
	wire [1:0] irq_wake = irq_rise & {2{main_power_on}}; // R13
	wire [3:0] wake_set = {data_fall[1], data_fall[0], irq_wake[1], irq_wake[0]}; // R11 R13
	wire [3:0] wake_clr = wr_wstat ? wr_data_q[3:0] : 4'h0;
	wire wake_d = wake_en_q[kbg_pkg::WAKE_GLOBAL_BIT] & |(wake_stat_q & wake_en_q[3:0]); // R12

	always_comb begin
		wake_stat_d = wake_set | (wake_stat_q & ~wake_clr);
		irq_stat_d = irq_stat_q & ~{2{rd_fire & rd_istat}};
		irq_stat_d[kbg_pkg::IRQ_RESET_PULSE] = irq_stat_d[kbg_pkg::IRQ_RESET_PULSE] |
			(fr_state_d == kbg_pkg::KBG_FR_PULSE && fr_state_q != kbg_pkg::KBG_FR_PULSE);
		irq_stat_d[kbg_pkg::IRQ_WAKE_RISE] = irq_stat_d[kbg_pkg::IRQ_WAKE_RISE] |
			(wake_d & ~out_wake_q);
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wake_stat_q <= 4'h0;
			irq_stat_q <= 2'h0;
		end else if (ce) begin
			wake_stat_q <= wake_stat_d; // R11
			irq_stat_q <= irq_stat_d;
		end
	end

	// Output stage.
	wire fr_n_d = (fr_state_d != kbg_pkg::KBG_FR_PULSE);
	wire kbd_rst_n_d = kbc_reset_out_n & (fr_n_d | ~fast_en); // R5
	wire key_iso = glue_q[kbg_pkg::GLUE_KEY_ISO_BIT];
	wire mouse_iso = glue_q[kbg_pkg::GLUE_MOUSE_ISO_BIT];
	// Isolated lines are held at their idle high level.
	wire [3:0] kbc_lines_d = pin_sync_q | {{2{mouse_iso}}, {2{key_iso}}}; // R14 R15

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			out_mask_n_q <= 1'b0;
			out_fr_n_q <= 1'b1; // R4
			out_kbd_pin_q <= 1'b1;
			out_kbc_lines_q <= 4'hF;
			out_irq_sel_q <= 2'h0;
			out_wake_q <= 1'b0;
			out_irq_q <= 1'b0;
		end else if (ce) begin
			out_mask_n_q <= kbc_gate_port_bit | fast_gate_q; // R1
			out_fr_n_q <= fr_n_d; // R2
			out_kbd_pin_q <= kbd_rst_n_d ^ reset_pin_invert; // R6
			out_kbc_lines_q <= kbc_lines_d; // R14 R15
			out_irq_sel_q <= irq_sel;
			out_wake_q <= wake_d; // R12
			out_irq_q <= |(irq_stat_d & irq_mask_q);
		end
	end

	assign s_axi_awready = aw_ready_q;
	assign s_axi_wready = w_ready_q;
	assign s_axi_bvalid = b_valid_q;
	assign s_axi_bresp = b_resp_q;
	assign s_axi_arready = ar_ready_q;
	assign s_axi_rvalid = r_valid_q;
	assign s_axi_rdata = r_data_q;
	assign s_axi_rresp = r_resp_q;
	assign cpu_addr_mask_n = out_mask_n_q;
	assign fast_reset_out_n = out_fr_n_q;
	assign fast_gate_out = fast_gate_q;
	assign keyboard_reset_pin = out_kbd_pin_q;
	assign kbc_key_clock = out_kbc_lines_q[0];
	assign kbc_key_data = out_kbc_lines_q[1];
	assign kbc_mouse_clock = out_kbc_lines_q[2];
	assign kbc_mouse_data = out_kbc_lines_q[3];
	assign key_irq = out_irq_sel_q[0];
	assign mouse_irq = out_irq_sel_q[1];
	assign kbc_hold_reset = ctrl_reset_q[kbg_pkg::CTRL_KBC_RESET_BIT];
	assign wake_event = out_wake_q;
	assign irq = out_irq_q;
endmodule

// ### kbg_glue_assertions.sv
`timescale 1ns/1ps
module kbg_glue_assertions #(
	parameter int CNT_W = 12
) (
	input wire logic clk, // Device clock.
	input wire logic rst_n, // System reset.
	input wire logic kbc_gate_port_bit, // Controller gate bit.
	input wire logic kbc_reset_out_n, // Controller reset.
	input wire logic reset_pin_invert, // Pin polarity.
	input wire logic kbc_key_irq, // Raw keyboard interrupt.
	input wire logic kbc_mouse_irq, // Raw mouse interrupt.
	input wire logic s_axi_bvalid, // Write response valid.
	input wire logic cpu_addr_mask_n, // CPU mask.
	input wire logic fast_reset_out_n, // Fast reset.
	input wire logic fast_gate_out, // Fast gate.
	input wire logic keyboard_reset_pin, // Combined reset pin.
	input wire logic key_irq, // Selected keyboard interrupt.
	input wire logic mouse_irq, // Selected mouse interrupt.
	input wire logic kbc_hold_reset // Controller hold.
);
	logic [15:0] low_cnt_q;
	logic [15:0] high_cnt_q;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			low_cnt_q <= 16'h0000;
			high_cnt_q <= 16'h0000;
		end else begin
			low_cnt_q <= fast_reset_out_n ? 16'h0000 : low_cnt_q + 16'h0001;
			high_cnt_q <= !fast_reset_out_n ? 16'h0000 : high_cnt_q + {15'h0000, ~&high_cnt_q};
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	mask_low_a: assert property (
		(!kbc_gate_port_bit && !fast_gate_out) [*2] ##1 !fast_gate_out |-> !cpu_addr_mask_n
	) else $error("mask high with both gate sources low");
	kbc_high_a: assert property (kbc_gate_port_bit |=> cpu_addr_mask_n)
		else $error("mask low with controller gate high");
	gate_high_a: assert property (fast_gate_out [*2] |-> cpu_addr_mask_n)
		else $error("mask low with fast gate high");
	pin_low_a: assert property (
		!kbc_reset_out_n |=> keyboard_reset_pin == $past(reset_pin_invert)
	) else $error("reset pin not asserted for controller reset");
	pin_high_a: assert property (
		kbc_reset_out_n && fast_reset_out_n ##1 fast_reset_out_n |->
			keyboard_reset_pin == !$past(reset_pin_invert)
	) else $error("reset pin asserted with both resets idle");
	key_rise_a: assert property (
		$rose(key_irq) |-> $past(kbc_key_irq) || $past(kbc_key_irq, 2) || $past(s_axi_bvalid)
	) else $error("keyboard interrupt rose without a cause");
	mouse_rise_a: assert property (
		$rose(mouse_irq) |-> $past(kbc_mouse_irq) || $past(kbc_mouse_irq, 2) || $past(s_axi_bvalid)
	) else $error("mouse interrupt rose without a cause");
	gate_write_a: assert property ($changed(fast_gate_out) |-> $rose(s_axi_bvalid))
		else $error("fast gate changed without a write");
	hold_write_a: assert property ($changed(kbc_hold_reset) |-> $rose(s_axi_bvalid))
		else $error("controller hold changed without a write");
	pulse_width_a: assert property (
		$rose(fast_reset_out_n) |-> low_cnt_q >= kbg_pkg::RESET_PULSE_CYC
	) else $error("fast reset pulse too short");
	delay_len_a: assert property (
		$fell(fast_reset_out_n) |-> high_cnt_q >= kbg_pkg::RESET_DELAY_CYC
	) else $error("fast reset delay too short");
endmodule
bind kbg_glue kbg_glue_assertions #(.CNT_W(CNT_W)) u_chk (
	.clk(clk), .rst_n(rst_n), .kbc_gate_port_bit(kbc_gate_port_bit),
	.kbc_reset_out_n(kbc_reset_out_n), .reset_pin_invert(reset_pin_invert),
	.kbc_key_irq(kbc_key_irq), .kbc_mouse_irq(kbc_mouse_irq), .s_axi_bvalid(s_axi_bvalid),
	.cpu_addr_mask_n(cpu_addr_mask_n), .fast_reset_out_n(fast_reset_out_n),
	.fast_gate_out(fast_gate_out), .keyboard_reset_pin(keyboard_reset_pin),
	.key_irq(key_irq), .mouse_irq(mouse_irq), .kbc_hold_reset(kbc_hold_reset)
);

// ### kbg_cpu_model.sv
`timescale 1ns/1ps
module kbg_cpu_model (
	input wire logic clk, // Device clock.
	input wire logic rst_n, // System reset.
	input wire logic fast_reset_out_n, // Fast reset from the glue.
	output int n_resets, // Reset pulses received.
	output int low_len // Low cycles of the last pulse.
);
	int low_q;
	// A pulse is counted when it ends, so its width is known.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			low_q <= 0;
			n_resets <= 0;
			low_len <= 0;
		end else if (!fast_reset_out_n) begin
			low_q <= low_q + 1;
		end else if (low_q != 0) begin
			n_resets <= n_resets + 1;
			low_len <= low_q;
			low_q <= 0;
		end
	end
endmodule

// ### test_kbg_glue.sv
`timescale 1ns/1ps
module test_kbg_glue;
	typedef struct {
		logic [kbg_pkg::ADDR_W-1:0] addr;
		logic [7:0] wr;
		logic [7:0] rd;
		logic [1:0] resp;
		logic gate;
		logic hold;
	} kbg_row_t;
	logic clk = 1'b0, rst_n = 1'b0, ce = 1'b1;
	logic [kbg_pkg::ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
	logic [31:0] s_axi_wdata = '0, s_axi_rdata, rdat;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic kbc_gate_port_bit = 1'b0, kbc_reset_out_n = 1'b1, kbc_key_irq = 1'b0;
	logic kbc_mouse_irq = 1'b0, kbc_data_read = 1'b0, main_power_on = 1'b1;
	logic reset_pin_invert = 1'b0, key_clock_line = 1'b1, key_data_line = 1'b1;
	logic mouse_clock_line = 1'b1, mouse_data_line = 1'b1, kbc_hold_reset;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
	logic [1:0] s_axi_bresp, s_axi_rresp, resp;
	logic cpu_addr_mask_n, fast_reset_out_n, fast_gate_out, keyboard_reset_pin, wake_event;
	logic kbc_key_clock, kbc_key_data, kbc_mouse_clock, kbc_mouse_data, key_irq, mouse_irq;
	int n_resets, low_len, cnt, base, n_fail = 0, n_tests = 0;
	kbg_row_t rows [8] = '{
		'{kbg_pkg::A_GLUE, 8'h04, 8'h04, kbg_pkg::RESP_OKAY, 1'b0, 1'b0},
		'{kbg_pkg::A_FAST_PORT, 8'h02, 8'h26, kbg_pkg::RESP_OKAY, 1'b1, 1'b0},
		'{kbg_pkg::A_FAST_PORT, 8'h00, 8'h24, kbg_pkg::RESP_OKAY, 1'b0, 1'b0},
		'{kbg_pkg::A_CTRL_RESET, 8'h40, 8'h40, kbg_pkg::RESP_OKAY, 1'b0, 1'b1},
		'{kbg_pkg::A_CTRL_RESET, 8'h00, 8'h00, kbg_pkg::RESP_OKAY, 1'b0, 1'b0},
		'{kbg_pkg::A_WAKE_EN, 8'h1F, 8'h1F, kbg_pkg::RESP_OKAY, 1'b0, 1'b0},
		'{kbg_pkg::A_IRQ_MASK, 8'h03, 8'h03, kbg_pkg::RESP_OKAY, 1'b0, 1'b0},
		'{12'h004, 8'h5A, 8'h00, kbg_pkg::RESP_SLVERR, 1'b0, 1'b0}
	};
	always #4 clk = ~clk;
	kbg_glue u_dut (.*);
	kbg_cpu_model u_cpu (.clk(clk), .rst_n(rst_n), .fast_reset_out_n(fast_reset_out_n),
		.n_resets(n_resets), .low_len(low_len));
	task automatic give_verdict();
		$display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic timed_out();
		n_fail++;
		$display("ERROR wait expected response seen timeout");
		give_verdict();
	endtask
	task automatic axi_wr(input logic [kbg_pkg::ADDR_W-1:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h000000, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge clk);
			n++;
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid && n < 100);
		if (!s_axi_bvalid) timed_out();
		resp = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task automatic axi_rd(input logic [kbg_pkg::ADDR_W-1:0] a);
		int n;
		n = 0;
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge clk);
			n++;
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid && n < 100);
		if (!s_axi_rvalid) timed_out();
		rdat = s_axi_rdata;
		resp = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	// Counts cycles until the fast reset reaches lvl; a miss is fatal only when must is set.
	task automatic wait_fast(input logic lvl, input int lim, input bit must);
		cnt = 0;
		while (fast_reset_out_n !== lvl && cnt < lim) begin
			@(posedge clk);
			cnt++;
		end
		if (must && fast_reset_out_n !== lvl) timed_out();
	endtask
	task automatic set_lines(input logic v);
		key_clock_line <= v;
		key_data_line <= v;
		mouse_clock_line <= v;
		mouse_data_line <= v;
		repeat (4) @(posedge clk);
	endtask
	initial begin
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		foreach (rows[i]) begin
			axi_wr(rows[i].addr, rows[i].wr);
			chk("bresp", resp, rows[i].resp);
			axi_rd(rows[i].addr);
			chk("rdata", rdat, {24'h000000, rows[i].rd});
			chk("rresp", resp, rows[i].resp);
			chk("fast_gate_out", fast_gate_out, rows[i].gate);
			chk("cpu_addr_mask_n", cpu_addr_mask_n, rows[i].gate);
			chk("kbc_hold_reset", kbc_hold_reset, rows[i].hold);
		end
		kbc_gate_port_bit <= 1'b1;
		repeat (3) @(posedge clk);
		chk("cpu_addr_mask_n", cpu_addr_mask_n, 1'b1);
		kbc_gate_port_bit <= 1'b0;
		base = n_resets;
		axi_wr(kbg_pkg::A_FAST_PORT, 8'h01);
		wait_fast(1'b0, 3000, 1'b1);
		chk("reset delay", cnt + 1 >= kbg_pkg::RESET_DELAY_CYC, 1);
		repeat (2) @(posedge clk);
		chk("keyboard_reset_pin", keyboard_reset_pin, 1'b0);
		wait_fast(1'b1, 1000, 1'b1);
		repeat (2) @(posedge clk);
		chk("pulse width", low_len >= kbg_pkg::RESET_PULSE_CYC, 1);
		chk("keyboard_reset_pin", keyboard_reset_pin, 1'b1);
		axi_rd(kbg_pkg::A_FAST_PORT);
		chk("rdata", rdat, 32'h00000025);
		axi_wr(kbg_pkg::A_FAST_PORT, 8'h01);
		wait_fast(1'b0, 2600, 1'b0);
		chk("pulse count", n_resets, base + 1);
		axi_wr(kbg_pkg::A_FAST_PORT, 8'h00);
		axi_wr(kbg_pkg::A_FAST_PORT, 8'h01);
		wait_fast(1'b0, 3000, 1'b1);
		wait_fast(1'b1, 1000, 1'b1);
		repeat (2) @(posedge clk);
		chk("pulse count", n_resets, base + 2);
		for (int inv = 0; inv < 2; inv++) begin
			reset_pin_invert <= inv[0];
			kbc_reset_out_n <= 1'b0;
			repeat (3) @(posedge clk);
			chk("keyboard_reset_pin", keyboard_reset_pin, inv[0]);
			kbc_reset_out_n <= 1'b1;
			repeat (3) @(posedge clk);
			chk("keyboard_reset_pin", keyboard_reset_pin, !inv[0]);
		end
		reset_pin_invert <= 1'b0;
		for (int sel = 0; sel < 2; sel++) begin
			axi_wr(kbg_pkg::A_GLUE, sel[0] ? 8'h1C : 8'h04);
			kbc_key_irq <= 1'b1;
			kbc_mouse_irq <= 1'b1;
			repeat (4) @(posedge clk);
			chk("key_irq", key_irq, 1'b1);
			chk("mouse_irq", mouse_irq, 1'b1);
			kbc_key_irq <= 1'b0;
			kbc_mouse_irq <= 1'b0;
			repeat (4) @(posedge clk);
			chk("key_irq", key_irq, sel[0]);
			chk("mouse_irq", mouse_irq, sel[0]);
			kbc_data_read <= 1'b1;
			@(posedge clk);
			kbc_data_read <= 1'b0;
			repeat (4) @(posedge clk);
			chk("key_irq", key_irq, 1'b0);
			chk("mouse_irq", mouse_irq, 1'b0);
		end
		chk("wake_event", wake_event, 1'b1);
		axi_rd(kbg_pkg::A_WAKE_STAT);
		chk("wake status", rdat, 32'h00000003);
		axi_wr(kbg_pkg::A_IRQ_MASK, 8'h00);
		@(posedge clk);
		chk("irq", irq, 1'b0);
		axi_wr(kbg_pkg::A_IRQ_MASK, 8'h03);
		@(posedge clk);
		chk("irq", irq, 1'b1);
		axi_rd(kbg_pkg::A_IRQ_STAT);
		chk("irq wake bit", rdat[1], 1'b1);
		repeat (2) @(posedge clk);
		chk("irq", irq, 1'b0);
		axi_wr(kbg_pkg::A_WAKE_STAT, 8'h03);
		repeat (2) @(posedge clk);
		chk("wake_event", wake_event, 1'b0);
		main_power_on <= 1'b0;
		kbc_key_irq <= 1'b1;
		repeat (4) @(posedge clk);
		kbc_key_irq <= 1'b0;
		axi_rd(kbg_pkg::A_WAKE_STAT);
		chk("wake status", rdat, 32'h00000000);
		axi_wr(kbg_pkg::A_GLUE, 8'h64);
		set_lines(1'b0);
		chk("isolated lines", {kbc_key_clock, kbc_key_data, kbc_mouse_clock, kbc_mouse_data}, 4'hF);
		axi_rd(kbg_pkg::A_WAKE_STAT);
		chk("wake status", rdat, 32'h0000000C);
		chk("wake_event", wake_event, 1'b1);
		axi_wr(kbg_pkg::A_WAKE_EN, 8'h0F);
		repeat (2) @(posedge clk);
		chk("wake_event", wake_event, 1'b0);
		axi_wr(kbg_pkg::A_GLUE, 8'h04);
		repeat (4) @(posedge clk);
		chk("passed lines", {kbc_key_clock, kbc_key_data, kbc_mouse_clock, kbc_mouse_data}, 4'h0);
		set_lines(1'b1);
		main_power_on <= 1'b1;
		axi_wr(kbg_pkg::A_FAST_PORT, 8'h03);
		repeat (5) @(posedge clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		chk("fast_gate_out", fast_gate_out, 1'b0);
		chk("fast_reset_out_n", fast_reset_out_n, 1'b1);
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		axi_rd(kbg_pkg::A_GLUE);
		chk("rdata", rdat, 32'h00000000);
		axi_wr(kbg_pkg::A_GLUE, 8'h04);
		axi_rd(kbg_pkg::A_FAST_PORT);
		chk("rdata", rdat, 32'h00000024);
		wait_fast(1'b0, 2600, 1'b0);
		chk("fast_reset_out_n", fast_reset_out_n, 1'b1);
		give_verdict();
	end
endmodule
